// >>> rtl/gpf_params.svh
// constants for the fast-alias gpio port block: offsets, bases, reset values
// assumes inclusion by bare name from rtl/ files
`ifndef GPF_PARAMS_SVH
`define GPF_PARAMS_SVH

`define GPF_OFS_OUTPUT_LEVEL   8'h00
`define GPF_OFS_OUTPUT_SET     8'h04
`define GPF_OFS_OUTPUT_CLEAR   8'h08
`define GPF_OFS_OUTPUT_TOGGLE  8'h0C
`define GPF_OFS_INPUT_LEVEL    8'h10
`define GPF_OFS_DIRECTION      8'h14
`define GPF_PORT_STRIDE        8'h40
`define GPF_REG_SPAN           8'h18
`define GPF_FAST_BASE          32'hF8000000
`define GPF_PERIPH_BASE        32'h400FF000
`define GPF_WINDOW_MASK        32'hFFFFFF80
`define GPF_RESET_WORD         32'h00000000
`define GPF_ERROR_WAIT         1

`endif

// >>> rtl/gpf_pkg.sv
// types for the fast-alias gpio port block
// assumes gpf_params.svh is compiled alongside
package gpf_pkg;
  typedef enum logic [1:0] {
    GPF_IDLE = 2'h0,
    GPF_ERR1 = 2'h1,
    GPF_ERR2 = 2'h3
  } gpf_err_t;

  typedef struct packed {
    logic [31:0] out_level;
    logic [31:0] dir;
    logic [31:0] in_level;
  } gpf_port_t;
endpackage

// >>> rtl/gpf_sync.sv
// three-stage pin synchroniser with agreement filter, one bit per pin
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module gpf_sync
  import gpf_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } gpf_sync_st_t;

  gpf_sync_st_t st_reg;
  gpf_sync_st_t st_next;

  // stage chain; a bit changes only once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.held[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.held;
endmodule // gpf_sync
`default_nettype wire

// >>> rtl/gpf_port.sv
// one gpio port: output level, direction, input capture
// assumes writes are single-cycle strobes already decoded by the caller
`timescale 1ns/1ps
`default_nettype none
`include "gpf_params.svh"
module gpf_port
  import gpf_pkg::*;
#(
  parameter logic [31:0] IMPL_MASK = 32'hFFFFFFFF
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wr_level,
  input  wire logic        wr_set,
  input  wire logic        wr_clear,
  input  wire logic        wr_toggle,
  input  wire logic        wr_dir,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] pin_sync,
  input  wire logic [31:0] digital_sel,
  input  wire logic        pcm_enable,
  output var  logic [31:0] out_level,
  output var  logic [31:0] dir,
  output var  logic [31:0] in_level
);
  gpf_port_t st_reg;
  gpf_port_t st_next;

  // register updates; writes act whether or not the port module is enabled
  always_comb begin
    st_next = st_reg;
    if (wr_level) begin
      st_next.out_level = wdata;
    end
    if (wr_set) begin
      st_next.out_level = st_reg.out_level | wdata;
    end
    if (wr_clear) begin
      st_next.out_level = st_reg.out_level & ~wdata;
    end
    if (wr_toggle) begin
      st_next.out_level = st_reg.out_level ^ wdata;
    end
    if (wr_dir) begin
      st_next.dir = wdata;
    end
    // input capture: frozen while disabled, zero when not digital
    if (pcm_enable) begin
      st_next.in_level = pin_sync & digital_sel & IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{`GPF_RESET_WORD, `GPF_RESET_WORD, `GPF_RESET_WORD};
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_level = st_reg.out_level;
  assign dir       = st_reg.dir;
  assign in_level  = st_reg.in_level;
endmodule // gpf_port
`default_nettype wire

// >>> rtl/gpf_top.sv
// gpio block with two ports, reached by a fast alias port and a peripheral port
// assumes: one clock; both access ports give full byte addresses;
// pin mux supplies gpio_fn/digital_sel; pad ring combines out, oe and in
`timescale 1ns/1ps
`default_nettype none
`include "gpf_params.svh"
module gpf_top
  import gpf_pkg::*;
#(
  parameter int          NPORT       = 2,
  parameter logic [31:0] IMPL_MASK_A = 32'hFFFFFFFF,
  parameter logic [31:0] IMPL_MASK_B = 32'hFFFFFFFF
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  // fast core i/o port
  input  wire logic              fio_sel,
  input  wire logic              fio_write,
  input  wire logic [31:0]       fio_addr,
  input  wire logic [31:0]       fio_wdata,
  output var  logic [31:0]       fio_rdata,
  output var  logic              fio_ready,
  output var  logic              fio_error,
  // peripheral bus port
  input  wire logic              per_sel,
  input  wire logic              per_write,
  input  wire logic [31:0]       per_addr,
  input  wire logic [31:0]       per_wdata,
  output var  logic [31:0]       per_rdata,
  output var  logic              per_ready,
  output var  logic              per_error,
  // pins and mux control
  input  wire logic [NPORT*32-1:0] pin_in,
  input  wire logic [NPORT*32-1:0] gpio_fn,
  input  wire logic [NPORT*32-1:0] digital_sel,
  input  wire logic [NPORT-1:0]    pcm_enable,
  output var  logic [NPORT*32-1:0] pin_out,
  output var  logic [NPORT*32-1:0] pin_oe
);
  typedef struct packed {
    gpf_err_t                fio_err;
    gpf_err_t                per_err;
    logic [31:0]             fio_rdata;
    logic                    fio_ready;
    logic                    fio_error;
    logic [31:0]             per_rdata;
    logic                    per_ready;
    logic                    per_error;
    logic [NPORT*32-1:0]     pin_out;
    logic [NPORT*32-1:0]     pin_oe;
  } gpf_top_st_t;

  gpf_top_st_t st_reg;
  gpf_top_st_t st_next;

  logic [NPORT*32-1:0] pin_sync;
  logic [NPORT*32-1:0] lvl_all;
  logic [NPORT*32-1:0] dir_all;
  logic [NPORT*32-1:0] in_all;
  logic [NPORT-1:0]    wr_level;
  logic [NPORT-1:0]    wr_set;
  logic [NPORT-1:0]    wr_clear;
  logic [NPORT-1:0]    wr_toggle;
  logic [NPORT-1:0]    wr_dir;
  logic [31:0]         wdata;
  logic                fio_hit;
  logic                per_hit;
  logic                fio_valid;
  logic                per_valid;
  logic [31:0]         fio_off;
  logic [31:0]         per_off;

  // pin synchroniser for all ports
  gpf_sync #(
    .WIDTH (NPORT*32)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // address checks: window hit and offset inside a defined register
  function automatic logic reg_ok(input logic [31:0] off);
    logic [7:0] lo;
    logic [7:0] port;
    lo   = {2'h0, off[5:0]};
    port = {2'h0, off[7:6]};
    reg_ok = (off[1:0] == 2'h0) && (lo < `GPF_REG_SPAN) &&
             ({24'h0, port} < NPORT) && (off[31:8] == 24'h0);
  endfunction

  assign fio_off   = fio_addr - `GPF_FAST_BASE;
  assign per_off   = per_addr - `GPF_PERIPH_BASE;
  assign fio_hit   = fio_sel && (st_reg.fio_err == GPF_IDLE);
  assign per_hit   = per_sel && (st_reg.per_err == GPF_IDLE) && !(fio_hit && fio_write);
  assign fio_valid = fio_hit && reg_ok(fio_off);
  assign per_valid = per_hit && reg_ok(per_off);
  assign wdata     = (fio_valid && fio_write) ? fio_wdata : per_wdata;

  // one write strobe set per port; fast port wins a same-cycle collision
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic        fw;
      logic        pw;
      logic [7:0]  fo;
      logic [7:0]  po;
      logic [7:0]  sel_o;
      localparam logic [31:0] PORT_MASK = (p == 0) ? IMPL_MASK_A : IMPL_MASK_B;
      assign fw    = fio_valid && fio_write && (fio_off[7:6] == 2'(p));
      assign pw    = per_valid && per_write && (per_off[7:6] == 2'(p));
      assign fo    = {2'h0, fio_off[5:0]};
      assign po    = {2'h0, per_off[5:0]};
      assign sel_o = fw ? fo : po;
      assign wr_level[p]  = (fw || pw) && (sel_o == `GPF_OFS_OUTPUT_LEVEL);
      assign wr_set[p]    = (fw || pw) && (sel_o == `GPF_OFS_OUTPUT_SET);
      assign wr_clear[p]  = (fw || pw) && (sel_o == `GPF_OFS_OUTPUT_CLEAR);
      assign wr_toggle[p] = (fw || pw) && (sel_o == `GPF_OFS_OUTPUT_TOGGLE);
      assign wr_dir[p]    = (fw || pw) && (sel_o == `GPF_OFS_DIRECTION);

      // the implemented-pin mask is fixed per port, so it goes down as a parameter
      gpf_port #(
        .IMPL_MASK (PORT_MASK)
      ) u_port (
        .clk         (clk),
        .rstn        (rstn),
        .wr_level    (wr_level[p]),
        .wr_set      (wr_set[p]),
        .wr_clear    (wr_clear[p]),
        .wr_toggle   (wr_toggle[p]),
        .wr_dir      (wr_dir[p]),
        .wdata       (wdata),
        .pin_sync    (pin_sync[p*32 +: 32]),
        .digital_sel (digital_sel[p*32 +: 32]),
        .pcm_enable  (pcm_enable[p]),
        .out_level   (lvl_all[p*32 +: 32]),
        .dir         (dir_all[p*32 +: 32]),
        .in_level    (in_all[p*32 +: 32])
      );
    end
  endgenerate

  // read multiplexer; write-only locations read zero
  function automatic logic [31:0] rd_word(input logic [31:0] off,
                                          input logic [NPORT*32-1:0] lv,
                                          input logic [NPORT*32-1:0] dr,
                                          input logic [NPORT*32-1:0] il);
    logic [31:0] r;
    int          p;
    r = 32'h00000000;
    p = int'(off[7:6]);
    if (p < NPORT) begin
      case ({2'h0, off[5:0]})
        `GPF_OFS_OUTPUT_LEVEL: r = lv[p*32 +: 32];
        `GPF_OFS_INPUT_LEVEL:  r = il[p*32 +: 32];
        `GPF_OFS_DIRECTION:    r = dr[p*32 +: 32];
        default:               r = 32'h00000000;
      endcase
    end
    rd_word = r;
  endfunction

  // answer state and pin drive
  always_comb begin
    st_next = st_reg;
    // fast port: valid answers in zero wait states, errors after one
    st_next.fio_ready = 1'b0;
    st_next.fio_error = 1'b0;
    st_next.fio_rdata = 32'h00000000;
    case (st_reg.fio_err)
      GPF_IDLE: begin
        if (fio_valid) begin
          st_next.fio_ready = 1'b1;
          st_next.fio_rdata = fio_write ? 32'h00000000 :
                              rd_word(fio_off, lvl_all, dir_all, in_all);
        end else if (fio_hit) begin
          st_next.fio_err = GPF_ERR1;
        end
      end
      GPF_ERR1: begin
        st_next.fio_ready = 1'b1;
        st_next.fio_error = 1'b1;
        st_next.fio_err   = GPF_ERR2;
      end
      GPF_ERR2: st_next.fio_err = GPF_IDLE;
      default:  st_next.fio_err = GPF_IDLE;
    endcase
    // peripheral port: same map and behaviour
    st_next.per_ready = 1'b0;
    st_next.per_error = 1'b0;
    st_next.per_rdata = 32'h00000000;
    case (st_reg.per_err)
      GPF_IDLE: begin
        if (per_valid) begin
          st_next.per_ready = 1'b1;
          st_next.per_rdata = per_write ? 32'h00000000 :
                              rd_word(per_off, lvl_all, dir_all, in_all);
        end else if (per_hit) begin
          st_next.per_err = GPF_ERR1;
        end
      end
      GPF_ERR1: begin
        st_next.per_ready = 1'b1;
        st_next.per_error = 1'b1;
        st_next.per_err   = GPF_ERR2;
      end
      GPF_ERR2: st_next.per_err = GPF_IDLE;
      default:  st_next.per_err = GPF_IDLE;
    endcase
    // pins: drive level only where gpio function and direction out
    st_next.pin_oe  = dir_all & gpio_fn;
    st_next.pin_out = lvl_all;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fio_rdata = st_reg.fio_rdata;
  assign fio_ready = st_reg.fio_ready;
  assign fio_error = st_reg.fio_error;
  assign per_rdata = st_reg.per_rdata;
  assign per_ready = st_reg.per_ready;
  assign per_error = st_reg.per_error;
  assign pin_out   = st_reg.pin_out;
  assign pin_oe    = st_reg.pin_oe;
endmodule // gpf_top
`default_nettype wire

// >>> bench/gpf_top_properties.sv
// checker for gpf_top: access timing, write effects on pins, reset
// assumes binding to gpf_top; one clock, active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "gpf_params.svh"
module gpf_chk #(parameter int NPORT = 2) (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 fio_sel,
  input wire logic                 fio_write,
  input wire logic [31:0]          fio_addr,
  input wire logic [31:0]          fio_wdata,
  input wire logic [31:0]          fio_rdata,
  input wire logic                 fio_ready,
  input wire logic                 fio_error,
  input wire logic                 per_sel,
  input wire logic [31:0]          per_addr,
  input wire logic                 per_ready,
  input wire logic                 per_error,
  input wire logic [NPORT*32-1:0]  gpio_fn,
  input wire logic [NPORT*32-1:0]  pin_out,
  input wire logic [NPORT*32-1:0]  pin_oe
);
  logic [1:0] fb, pb; // refusal countdown after an erroring take
  wire logic fok = (fio_addr & `GPF_WINDOW_MASK) == `GPF_FAST_BASE
                   && fio_addr[1:0] == 2'h0 && fio_addr[5:0] <= 6'h14;
  wire logic pok = (per_addr & `GPF_WINDOW_MASK) == `GPF_PERIPH_BASE
                   && per_addr[1:0] == 2'h0 && per_addr[5:0] <= 6'h14;
  wire logic ft = fio_sel && fb == 2'h0;
  wire logic pt = per_sel && pb == 2'h0;
  wire logic fwa = ft && fok && fio_write && !fio_addr[6];
  wire logic [31:0] pa = pin_out[31:0];
  // countdowns cover the two cycles after each erroring take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fb <= 2'h0;
      pb <= 2'h0;
    end else begin
      fb <= (ft && !fok) ? 2'h2 : fb - {1'b0, fb != 2'h0};
      pb <= (pt && !pok) ? 2'h2 : pb - {1'b0, pb != 2'h0};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence err_wait_s;
    !fio_ready ##1 (fio_ready && fio_error);
  endsequence
  sequence per_ok_s;
    per_ready && !per_error;
  endsequence
  fast_ok_ready_a:
    assert property (ft && fok |=> fio_ready && !fio_error) else $error("fast access late");
  fast_err_wait_a:
    assert property (ft && !fok |=> err_wait_s) else $error("fast error timing wrong");
  per_ok_ready_a:
    assert property (pt && pok && !(ft && fio_write) |=> per_ok_s) else $error("per access late");
  wo_read_zero_a:
    assert property (ft && fok && !fio_write && !fio_addr[4] && fio_addr[3:2] != 2'h0
      |=> fio_rdata == 32'h0) else $error("write-only read not zero");
  set_pin_a:
    assert property (fwa && fio_addr[4:0] == 5'h04 |-> ##2
      (pa & $past(fio_wdata, 2)) == $past(fio_wdata, 2)) else $error("set not on pins");
  clear_pin_a:
    assert property (fwa && fio_addr[4:0] == 5'h08 |-> ##2
      (pa & $past(fio_wdata, 2)) == 32'h0) else $error("clear not on pins");
  toggle_pin_a:
    assert property (fwa && fio_addr[4:0] == 5'h0C |-> ##2
      pa == ($past(pa) ^ $past(fio_wdata, 2))) else $error("toggle not on pins");
  oe_needs_fn_a:
    assert property ((pin_oe & ~$past(gpio_fn)) == '0) else $error("pin driven without gpio");
  err_with_ready_a:
    assert property (fio_error |-> fio_ready) else $error("error without ready");
  reset_quiet_a:
    assert property ($rose(rstn) |-> pin_out == '0 && !fio_ready) else $error("reset not clean");
endmodule // gpf_chk
bind gpf_top gpf_chk #(.NPORT(NPORT)) u_chk (.clk(clk), .rstn(rstn), .fio_sel(fio_sel),
  .fio_write(fio_write), .fio_addr(fio_addr), .fio_wdata(fio_wdata), .fio_rdata(fio_rdata),
  .fio_ready(fio_ready), .fio_error(fio_error), .per_sel(per_sel), .per_addr(per_addr),
  .per_ready(per_ready), .per_error(per_error), .gpio_fn(gpio_fn), .pin_out(pin_out),
  .pin_oe(pin_oe));
`default_nettype wire

// >>> bench/gpf_pins.sv
// board model for the gpio pins: pads read back what the block drives
// assumes one bit per pin; ext is the outside level of undriven pins
`timescale 1ns/1ps
`default_nettype none
module gpf_pins (
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe,
  input  wire logic [63:0] ext,
  output wire logic [63:0] pin_in
);
  // a driven pad shows the block's level, others follow outside
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // gpf_pins
`default_nettype wire

// >>> bench/test_gpio_port_fast_alias.sv
// self-checking bench for gpf_top: registers on both paths, pins, errors
// assumes gpf_pins as the board and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "gpf_params.svh"
module test_gpio_port_fast_alias;
  localparam logic [31:0] MB = 32'h0000FFFF; // upper half of port b absent
  logic        clk = 1'b0, rstn = 1'b0, fs = 1'b0, ps = 1'b0, bw = 1'b0;
  logic [7:0]  bo = 8'h00;
  logic [7:0]  bad [6] = '{8'h18, 8'h3C, 8'h58, 8'h7C, 8'h02, 8'h41};
  logic [31:0] bd = 32'h0, frd, prd;
  logic [31:0] lvl [2] = '{default: 32'h0}, dir [2] = '{default: 32'h0}, ex [2];
  logic        frdy, ferr, prdy, perr;
  logic [63:0] pin, pout, poe, fn = 64'h0, dsel = 64'h0, ext = 64'h0;
  logic [1:0]  pcm = 2'h3;
  int          n_errors = 0, check_count = 0, cyc = 0;
  // clock of 40 ns
  always #20 clk = ~clk;
  gpf_top #(.IMPL_MASK_B(MB)) dut (.clk(clk), .rstn(rstn),
    .fio_sel(fs), .fio_write(bw), .fio_addr(`GPF_FAST_BASE | {24'h0, bo}), .fio_wdata(bd),
    .fio_rdata(frd), .fio_ready(frdy), .fio_error(ferr),
    .per_sel(ps), .per_write(bw), .per_addr(`GPF_PERIPH_BASE | {24'h0, bo}), .per_wdata(bd),
    .per_rdata(prd), .per_ready(prdy), .per_error(perr),
    .pin_in(pin), .gpio_fn(fn), .digital_sel(dsel), .pcm_enable(pcm),
    .pin_out(pout), .pin_oe(poe));
  gpf_pins u_pins (.pin_out(pout), .pin_oe(poe), .ext(ext), .pin_in(pin));
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one access: strobe for one cycle, then count cycles to the answer
  task automatic acc(input bit p, input bit w, input logic [7:0] o, input logic [31:0] d,
                     output logic [31:0] r, output logic e, output int n);
    @(posedge clk) #1;
    bw = w;
    bo = o;
    bd = d;
    if (p) ps = 1'b1;
    else fs = 1'b1;
    @(posedge clk) #1;
    ps = 1'b0;
    fs = 1'b0;
    n = 1;
    while (!(p ? prdy : frdy) && n < 4) begin
      @(posedge clk) #1;
      n++;
    end
    r = p ? prd : frd;
    e = p ? perr : ferr;
  endtask
  // expected input word of one port
  function automatic logic [31:0] ein(int p);
    logic [31:0] oe;
    oe = dir[p] & fn[p*32+:32];
    return ((oe & lvl[p]) | (~oe & ext[p*32+:32])) & dsel[p*32+:32] & (p == 1 ? MB : '1);
  endfunction
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    logic [31:0] r, d, x;
    logic        e;
    int          n, p, q, k;
    void'($urandom(93165));
    fn = {$urandom, $urandom};
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 12; i++) begin
      acc(i % 2, 1'b0, 8'((i / 6) * 64 + (i % 6) * 4), 32'h0, r, e, n);
      chk(r, 32'h0);
    end
    // random writes on one path, read back on the other
    for (int i = 0; i < 80; i++) begin
      p = $urandom % 2;
      q = $urandom % 2;
      k = $urandom % 6;
      d = $urandom;
      pcm = 2'($urandom);
      if (k == 4) k = 5;
      acc(q[0], 1'b1, 8'(p * 64 + k * 4), d, r, e, n);
      chk(32'(n), 32'h1);
      case (k)
        0: lvl[p] = d;
        1: lvl[p] = lvl[p] | d;
        2: lvl[p] = lvl[p] & ~d;
        3: lvl[p] = lvl[p] ^ d;
        default: dir[p] = d;
      endcase
      acc(~q[0], 1'b0, 8'(p * 64 + k * 4), 32'h0, r, e, n);
      x = (k == 0) ? lvl[p] : (k == 5) ? dir[p] : 32'h0;
      chk(r, x);
      acc(q[0], 1'b0, 8'(p * 64), 32'h0, r, e, n);
      chk(r, lvl[p]);
      chk(pout[p*32+:32], lvl[p]);
      chk(poe[p*32+:32], dir[p] & fn[p*32+:32]);
    end
    // inputs follow the pins while enabled and hold while disabled
    for (int i = 0; i < 6; i++) begin
      ext = {$urandom, $urandom};
      dsel = {$urandom, $urandom};
      pcm = (i % 2) ? 2'h0 : 2'h3;
      repeat (8) @(posedge clk);
      for (int j = 0; j < 2; j++) begin
        if (pcm != 2'h0) ex[j] = ein(j);
        acc(j % 2 == 0, 1'b0, 8'(j * 64 + 16), 32'h0, r, e, n);
        chk(r, ex[j]);
      end
    end
    // gap and misaligned addresses on both paths
    foreach (bad[i]) begin
      acc(i % 2, i % 3 == 0, bad[i], $urandom, r, e, n);
      chk({31'h0, e}, 32'h1);
      chk(32'(n), 32'h2);
    end
    acc(1'b0, 1'b0, 8'h00, 32'h0, r, e, n);
    chk(r, lvl[0]);
    print_verdict;
  end
endmodule // test_gpio_port_fast_alias
`default_nettype wire
